// *** mem_pin_interface.sv ***
// Purpose: One channel's DDR4 pin interface: command, address, data, check byte
// Assumes: Core on ref_clk; pin logic on link_clk; two instances make two channels
// Notes:   Behaviour
// Behaviour
// - 64-bit two-way data bus per channel
// - 8-bit two-way check byte bus
// - Strobe pairs mark data; ninth only with check
// - One differential clock pair per rank
// - One clock enable per rank, power states
// - One active-low select per rank
// - One termination control per rank
// - 17-bit multiplexed row and column address
// - Top three address lines carry commands
// - Bits 16/15/14 act as row/column/write strobes
// - Bit 10 high requests auto-precharge on access
// - Bit 10 high on precharge means all banks
// - Bit 12 low requests burst chop
// - Bank lines select bank or mode register
`timescale 1ns/10ps
module mem_pin_interface
  import mem_pins_pkg::*;
(
  input  wire logic                ref_clk,           // Core clock
  input  wire logic                rst_n,             // Core reset
  input  wire logic                link_clk,          // Memory clock domain
  input  wire logic                req_valid,         // Command request, held until ack
  input  wire logic [2:0]          req_op,            // Command code
  input  wire logic [1:0]          req_rank,          // Target rank
  input  wire logic [BANK_W-1:0]   req_bank,          // Bank or mode register
  input  wire logic [ADDR_W-1:0]   req_addr,          // Row or column address
  input  wire logic                req_autopre,       // Auto-precharge / all banks
  input  wire logic                req_chop,          // Burst chop request
  input  wire logic                check_en,          // Check-byte modules fitted
  input  wire logic [3:0]          cke_req,           // Clock enable per rank
  input  wire logic [3:0]          odt_req,           // Termination per rank
  input  wire logic                wdata_valid,       // Write beat valid
  output logic                     wdata_ready,       // Write beat accepted
  input  wire logic [DATA_W-1:0]   wdata,             // Write beat
  output logic                     req_ack,           // Toggles when command done
  output logic                     rd_valid,          // Read beat valid, one-cycle pulse
  output logic [DATA_W-1:0]        rd_data,           // Read beat
  output logic                     rd_check_err,      // Check byte mismatch
  output logic [3:0]               mem_clock_true,    // Rank clocks
  output logic [3:0]               mem_clock_comp,
  output logic [3:0]               rank_clock_enable,
  output logic [3:0]               rank_select_n,
  output logic [3:0]               rank_termination,
  output logic                     act_n,             // Activation qualifier
  output logic [ADDR_W-1:0]        row_col_address,
  output logic [BANK_W-1:0]        bank_address,
  input  wire logic [DATA_W-1:0]   data_bus_in,
  output logic [DATA_W-1:0]        data_bus_out,
  output logic [DATA_W-1:0]        data_bus_oe,
  input  wire logic [CHECK_W-1:0]  check_byte_bus_in,
  output logic [CHECK_W-1:0]       check_byte_bus_out,
  output logic [CHECK_W-1:0]       check_byte_bus_oe,
  input  wire logic [STROBE_N-1:0] strobe_true_in,
  input  wire logic [STROBE_N-1:0] strobe_comp_in,
  output logic [STROBE_N-1:0]      strobe_true_out,
  output logic [STROBE_N-1:0]      strobe_comp_out,
  output logic [STROBE_N-1:0]      strobe_oe
);

  // Check byte: XOR of each data byte lane per bit
  function automatic logic [CHECK_W-1:0] check_of(input logic [DATA_W-1:0] d);
    logic [CHECK_W-1:0] c;
    c = '0;
    for (int i = 0; i < DATA_W/8; i++)
      c = c ^ d[i*8 +: 8];
    return c;
  endfunction

  // Core-domain state
  typedef struct packed
  {
    logic                rd_tgl;     // Read toggle sync stages
    logic                rd_tgl_s;
    logic                rd_tgl_seen;
    logic                ack_s1;     // Ack toggle sync stages
    logic                ack_s2;
    logic                ack_out;
    logic                rd_valid;
    logic [DATA_W-1:0]   rd_data;
    logic                rd_err;
  } core_s;

  // Link-domain state
  typedef struct packed
  {
    link_state_e         st;
    logic                rq_s1;      // Request level sync
    logic                rq_s2;
    logic                busy_done;  // Request served, wait for drop
    logic                ack_tgl;
    logic                rd_tgl;
    logic [DATA_W-1:0]   rd_hold;
    logic                rd_err;
    logic                clk_ph;
    logic [3:0]          cke;
    logic [3:0]          cs_n;
    logic [3:0]          odt;
    logic                act_n;
    logic [ADDR_W-1:0]   addr;
    logic [BANK_W-1:0]   bank;
    logic [DATA_W-1:0]   dq_o;
    logic [CHECK_W-1:0]  ck_o;
    logic                dq_oe;
    logic                ck_oe;
    logic [STROBE_N-1:0] dqs_oe;
    logic [STROBE_N-1:0] sp_s1;      // Strobe sync stages
    logic [STROBE_N-1:0] sp_s2;
    logic [STROBE_N-1:0] sp_prev;
  } link_s;

  core_s c_q, c_d;
  link_s l_q, l_d;
  logic                f_valid;
  logic [BEAT_W-1:0]   f_data;
  logic                f_ready;
  logic                strobe_cross;
  logic [STROBE_N-1:0] lanes_used;

  // Write beats with their check byte enter the buffer together
  beat_fifo #(.WIDTH(BEAT_W), .DEPTH(FIFO_DEPTH)) wr_fifo_u
  (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (wdata_valid),
    .in_ready  (wdata_ready),
    .in_data   ({check_of(wdata), wdata}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );
  // Buffer never drains; the link path reads the head word straight from the buffer
  // Drain held off: the head word stays put, so the link side may read it safely
  assign f_ready = 1'b0;

  // Ninth strobe lane only with check-byte modules
  assign lanes_used   = check_en ? {STROBE_N{1'b1}} : {1'b0, {(STROBE_N-1){1'b1}}};
  // Read data is sampled on a rising crossing of the first strobe lane
  assign strobe_cross = l_q.sp_s2[0] && !l_q.sp_prev[0];

  // Core domain: synchronise toggles, present read beats
  always_comb
  begin
    c_d          = c_q;
    c_d.ack_s1   = l_q.ack_tgl;
    c_d.ack_s2   = c_q.ack_s1;
    c_d.ack_out  = c_q.ack_s2;
    c_d.rd_tgl   = l_q.rd_tgl;
    c_d.rd_tgl_s = c_q.rd_tgl;
    c_d.rd_valid = 1'b0;
    if (c_q.rd_tgl_s != c_q.rd_tgl_seen)
    begin
      c_d.rd_tgl_seen = c_q.rd_tgl_s;
      c_d.rd_valid    = 1'b1;
      c_d.rd_data     = l_q.rd_hold;  // Stable since toggle
      c_d.rd_err      = l_q.rd_err;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      c_q <= '0;
    else
      c_q <= c_d;
  end

  // Link domain: command encoding and data pins
  always_comb
  begin
    l_d         = l_q;
    l_d.rq_s1   = req_valid;
    l_d.rq_s2   = l_q.rq_s1;
    l_d.sp_s1   = strobe_true_in & ~strobe_comp_in;
    l_d.sp_s2   = l_q.sp_s1;
    l_d.sp_prev = l_q.sp_s2;
    l_d.clk_ph  = ~l_q.clk_ph;
    l_d.cke     = cke_req;
    l_d.odt     = odt_req;
    l_d.cs_n    = RESET_CS;
    l_d.act_n   = 1'b1;
    l_d.addr[A_CMD_HI:A_CMD_LO] = CMD_NOP;
    l_d.dq_oe   = 1'b0;
    l_d.ck_oe   = 1'b0;
    l_d.dqs_oe  = '0;
    if (!l_q.rq_s2)
      l_d.busy_done = 1'b0;
    case (l_q.st)
      LS_IDLE:
      begin
        if (l_q.rq_s2 && !l_q.busy_done)
        begin
          l_d.cs_n[req_rank] = 1'b0;
          l_d.bank           = req_bank;
          l_d.addr           = req_addr;
          l_d.busy_done      = 1'b1;
          case (mem_op_e'(req_op))
            OP_ACTIVATE:
              l_d.act_n = 1'b0;
            OP_READ:
            begin
              l_d.addr[A_CMD_HI:A_CMD_LO] = 3'b101;
              l_d.addr[A_AUTOPRE] = req_autopre;
              l_d.addr[A_CHOP]    = ~req_chop;
              l_d.st              = LS_READ;
            end
            OP_WRITE:
            begin
              l_d.addr[A_CMD_HI:A_CMD_LO] = 3'b100;
              l_d.addr[A_AUTOPRE] = req_autopre;
              l_d.addr[A_CHOP]    = ~req_chop;
              l_d.st              = LS_WRITE;
            end
            OP_PRECHG:
            begin
              l_d.addr[A_CMD_HI:A_CMD_LO] = 3'b010;
              l_d.addr[A_AUTOPRE] = req_autopre;
            end
            OP_MODESET:
              l_d.addr[A_CMD_HI:A_CMD_LO] = 3'b000;
            OP_REFRESH:
              l_d.addr[A_CMD_HI:A_CMD_LO] = 3'b001;
            default:
              l_d.cs_n = RESET_CS;
          endcase
          if (mem_op_e'(req_op) != OP_READ && mem_op_e'(req_op) != OP_WRITE)
            l_d.ack_tgl = ~l_q.ack_tgl;
        end
      end
      LS_WRITE:
      begin
        // Beat leaves with every used strobe; check byte driven with it only when check_en is set
        l_d.dq_o   = f_data[DATA_W-1:0];
        l_d.ck_o   = f_data[BEAT_W-1:DATA_W];
        l_d.dq_oe  = 1'b1;
        l_d.ck_oe  = check_en;
        l_d.dqs_oe = lanes_used;
        l_d.st      = LS_IDLE;
        l_d.ack_tgl = ~l_q.ack_tgl;
      end
      LS_READ:
      begin
        if (strobe_cross)
        begin
          l_d.rd_hold = data_bus_in;
          l_d.rd_err  = check_en && (check_of(data_bus_in) != check_byte_bus_in);
          l_d.rd_tgl  = ~l_q.rd_tgl;
          l_d.ack_tgl = ~l_q.ack_tgl;
          l_d.st      = LS_IDLE;
        end
      end
      default:
        l_d.st = LS_IDLE;
    endcase
  end

  always_ff @(posedge link_clk)
  begin
    if (!rst_n)
    begin
      l_q       <= '0;
      l_q.st    <= LS_IDLE;
      l_q.cs_n  <= RESET_CS;
      l_q.cke   <= RESET_CKE;
      l_q.odt   <= RESET_ODT;
      l_q.act_n <= 1'b1;
    end
    else
      l_q <= l_d;
  end

  // Outputs from flip-flops; complement clock and strobe pins through an inverter
  assign req_ack            = c_q.ack_out;
  assign rd_valid           = c_q.rd_valid;
  assign rd_data            = c_q.rd_data;
  assign rd_check_err       = c_q.rd_err;
  assign mem_clock_true     = {RANK_N{l_q.clk_ph}};
  assign mem_clock_comp     = {RANK_N{~l_q.clk_ph}};
  assign rank_clock_enable  = l_q.cke;
  assign rank_select_n      = l_q.cs_n;
  assign rank_termination   = l_q.odt;
  assign act_n              = l_q.act_n;
  assign row_col_address    = l_q.addr;
  assign bank_address       = l_q.bank;
  assign data_bus_out       = l_q.dq_o;
  assign data_bus_oe        = {DATA_W{l_q.dq_oe}};
  assign check_byte_bus_out = l_q.ck_o;
  assign check_byte_bus_oe  = {CHECK_W{l_q.ck_oe}};
  assign strobe_true_out    = {STROBE_N{l_q.clk_ph}};
  assign strobe_comp_out    = {STROBE_N{~l_q.clk_ph}};
  assign strobe_oe          = l_q.dqs_oe;

  // Selects idle high while no request is active
  property sel_idle_p;
    @(posedge link_clk) disable iff (!rst_n)
      !l_q.rq_s2 |=> (rank_select_n == RESET_CS);
  endproperty
  sel_idle_a: assert property (sel_idle_p) else $error("select active without request");

  write_pins_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    (l_q.st == LS_WRITE) |=> (data_bus_oe == {DATA_W{1'b1}}))
    else $error("data bus not driven in write beat");

  check_lane_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    (!check_en && l_q.st == LS_WRITE) |=> !strobe_oe[STROBE_N-1] && check_byte_bus_oe == '0)
    else $error("check lane driven without check modules");

  clock_pair_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    mem_clock_true == ~mem_clock_comp)
    else $error("clock pair not complementary");

  cke_follow_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    ##1 rank_clock_enable == $past(cke_req))
    else $error("clock enable does not follow request");

  odt_follow_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    ##1 rank_termination == $past(odt_req))
    else $error("termination does not follow request");

  act_cmd_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    !act_n |-> $countones(~rank_select_n) == 1)
    else $error("activate without one select");

  read_cmd_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    (l_q.st == LS_IDLE && $past(l_q.st) == LS_IDLE && l_d.st == LS_READ)
    |=> row_col_address[A_CMD_HI:A_CMD_LO] == 3'b101 && act_n)
    else $error("read command lines wrong");
endmodule

// *** mem_pins_pkg.sv ***
// Purpose: Shared constants for the two-channel DDR4 pin interface
// Assumes: One core clock at 100 MHz and one link clock per the link side
// Notes:   Widths are fixed; counts are in link-clock cycles
package mem_pins_pkg;
  localparam int DATA_W      = 64;     // Data bits per channel
  localparam int CHECK_W     = 8;      // Check byte per channel
  localparam int STROBE_N    = 9;      // Strobe pairs incl. check lane
  localparam int RANK_N      = 4;      // Ranks per channel
  localparam int ADDR_W      = 17;     // Row/column address width
  localparam int BANK_W      = 2;      // Bank address width
  localparam int BEAT_W      = DATA_W + CHECK_W; // One beat incl. check byte
  localparam int FIFO_DEPTH  = 4;      // Write data buffer depth
  localparam int A_AUTOPRE   = 10;     // Auto-precharge / all-banks bit
  localparam int A_CHOP      = 12;     // Burst chop bit, low chops
  localparam int A_CMD_LO    = 14;     // Write enable line
  localparam int A_CMD_MID   = 15;     // Column strobe line
  localparam int A_CMD_HI    = 16;     // Row strobe line
  localparam logic [2:0] CMD_NOP  = 3'h7; // Command lines idle
  localparam logic [3:0] RESET_CKE = 4'h0; // Clock enables low in reset
  localparam logic [3:0] RESET_CS  = 4'hF; // Selects idle high in reset
  localparam logic [3:0] RESET_ODT = 4'h0; // Termination off in reset

  // Commands offered by the core
  typedef enum logic [2:0]
  {
    OP_NONE     = 3'b000,
    OP_ACTIVATE = 3'b001,
    OP_READ     = 3'b010,
    OP_WRITE    = 3'b011,
    OP_PRECHG   = 3'b100,
    OP_MODESET  = 3'b101,
    OP_REFRESH  = 3'b110
  } mem_op_e;

  // Link-side sequencer state
  typedef enum logic [1:0]
  {
    LS_IDLE  = 2'b00,
    LS_WRITE = 2'b01,
    LS_READ  = 2'b10
  } link_state_e;
endpackage

// *** beat_fifo.sv ***
// Purpose: Small valid/ready FIFO for write beats
// Assumes: Single clock, synchronous active-low reset
// Notes:   Full and empty are exact; no overflow is possible
`timescale 1ns/10ps
module beat_fifo
  import mem_pins_pkg::*;
#(
  parameter int WIDTH = 72,
  parameter int DEPTH = 4
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  // Pointers and count in one struct; storage kept apart
  typedef struct packed
  {
    logic [PW-1:0] wr;   // Write pointer
    logic [PW-1:0] rd;   // Read pointer
    logic [PW:0]   cnt;  // Words held
  } fifo_s;

  fifo_s            s_q, s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];   // Storage
  logic             push, pop;

  assign in_ready  = (s_q.cnt != (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = mem_q[s_q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count update
  always_comb
  begin
    s_d = s_q;
    if (push)
      s_d.wr = s_q.wr + PW'(1);
    if (pop)
      s_d.rd = s_q.rd + PW'(1);
    s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  // Register state and storage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
    if (push)
      mem_q[s_q.wr] <= in_data;
  end
endmodule

// *** mem_rank_model.sv ***
// Purpose: Behavioural DDR4 ranks on the far side of one channel
// Assumes: Controller pins change just after rising link_clk edges
// Notes:   Released data lines show the inverse of the last value driven
`timescale 1ns/10ps
module mem_rank_model
  import mem_pins_pkg::*;
(
  input  wire logic                link_clk,
  input  wire logic [3:0]          rank_select_n,
  input  wire logic                act_n,
  input  wire logic [ADDR_W-1:0]   row_col_address,
  input  wire logic [BANK_W-1:0]   bank_address,
  input  wire logic [DATA_W-1:0]   data_bus_out,
  input  wire logic [DATA_W-1:0]   data_bus_oe,
  input  wire logic [CHECK_W-1:0]  check_byte_bus_out,
  input  wire logic [DATA_W-1:0]   rd_word,
  input  wire logic [CHECK_W-1:0]  rd_check,
  output logic [DATA_W-1:0]        data_bus_in,
  output logic [CHECK_W-1:0]       check_byte_bus_in,
  output logic [STROBE_N-1:0]      strobe_true_in,
  output logic [STROBE_N-1:0]      strobe_comp_in
);
  logic [23:0] cmd_q [$];  // Commands seen: selects, qualifier, bank, address
  logic [71:0] beat_q [$]; // Write beats: check byte over data
  int          rd_t = -1;  // Link cycles since a read, -1 when idle

  // Start levels: strobes parked low/high, data lines at 5A/A5 patterns until the first read drives its beat
  initial
  begin
    data_bus_in = 64'h5A5A5A5A5A5A5A5A;
    check_byte_bus_in = 8'hA5;
    strobe_true_in = '0;
    strobe_comp_in = '1;
  end

  // Capture commands and write beats, answer reads with one beat
  always @(posedge link_clk)
  begin
    // Command lines taken on rising link_clk edges with any select low
    if (rank_select_n != 4'hF)
    begin
      cmd_q.push_back({rank_select_n, act_n, bank_address, row_col_address});
      if (act_n && row_col_address[16:14] == 3'h5) rd_t = 0;
    end
    // Beat taken together with its check byte
    if (&data_bus_oe) beat_q.push_back({check_byte_bus_out, data_bus_out});
    if (rd_t >= 0) rd_t++;
    // Data and check byte settle before the strobe crossing
    if (rd_t == 3)
    begin
      data_bus_in <= rd_word;
      check_byte_bus_in <= rd_check;
    end
    // Rising crossing on every strobe pair
    if (rd_t == 4)
    begin
      strobe_true_in <= '1;
      strobe_comp_in <= '0;
    end
    // Release: strobes parked, data inverted so stale values never match
    if (rd_t == 9)
    begin
      strobe_true_in <= '0;
      strobe_comp_in <= '1;
      data_bus_in <= ~data_bus_in;
      check_byte_bus_in <= ~check_byte_bus_in;
      rd_t = -1;
    end
  end
endmodule

// *** mem_pin_interface_test.sv ***
// Purpose: Self-checking bench for one DDR4 channel pin interface
// Assumes: Link clock of 32 ns with no phase relation to the core clock
// Notes:   Each command is compared with what the rank model captured
`timescale 1ns/10ps
module mem_pin_interface_test
  import mem_pins_pkg::*;
;
  logic                ref_clk = 1'b0;    // Core clock
  logic                link_clk = 1'b0;   // Memory clock
  logic                rst_n = 1'b0;      // Shared reset
  logic                req_valid = 1'b0;  // Request and its fields
  logic [2:0]          req_op = 3'h0;
  logic [1:0]          req_rank = 2'h0;
  logic [BANK_W-1:0]   req_bank = '0;
  logic [ADDR_W-1:0]   req_addr = '0;
  logic                req_autopre = 1'b0;
  logic                req_chop = 1'b0;
  logic                check_en = 1'b1;   // Check-byte modules fitted
  logic [3:0]          cke_req = 4'h0;    // Per-rank levels
  logic [3:0]          odt_req = 4'h0;
  logic                wdata_valid = 1'b0;
  logic [DATA_W-1:0]   wdata = '0;
  logic [DATA_W-1:0]   rd_word = '0;      // Read beat the model returns
  logic [CHECK_W-1:0]  rd_check = '0;
  logic [DATA_W-1:0]   head;              // First beat buffered
  logic                rd_seen, rd_prev;  // Read result seen
  logic [STROBE_N-1:0] wr_dqs = '0;       // Strobe enables in the write beat
  logic [CHECK_W-1:0]  wr_ckoe = '0;      // Check lane enables in the write beat
  int                  fail_count = 0;
  int                  tests_run = 0;
  int                  cyc = 0;
  int                  n;
  wire                 wdata_ready, req_ack, rd_valid, rd_check_err, act_n;
  wire [DATA_W-1:0]    rd_data, data_bus_in, data_bus_out, data_bus_oe;
  wire [CHECK_W-1:0]   check_byte_bus_in, check_byte_bus_out, check_byte_bus_oe;
  wire [3:0]           mem_clock_true, mem_clock_comp, rank_clock_enable;
  wire [3:0]           rank_select_n, rank_termination;
  wire [ADDR_W-1:0]    row_col_address;
  wire [BANK_W-1:0]    bank_address;
  wire [STROBE_N-1:0]  strobe_true_in, strobe_comp_in, strobe_true_out;
  wire [STROBE_N-1:0]  strobe_comp_out, strobe_oe;

  mem_pin_interface u_dut
  (
    .ref_clk, .rst_n, .link_clk, .req_valid, .req_op, .req_rank, .req_bank,
    .req_addr, .req_autopre, .req_chop, .check_en, .cke_req, .odt_req,
    .wdata_valid, .wdata_ready, .wdata, .req_ack, .rd_valid, .rd_data,
    .rd_check_err, .mem_clock_true, .mem_clock_comp, .rank_clock_enable,
    .rank_select_n, .rank_termination, .act_n, .row_col_address, .bank_address,
    .data_bus_in, .data_bus_out, .data_bus_oe, .check_byte_bus_in,
    .check_byte_bus_out, .check_byte_bus_oe, .strobe_true_in, .strobe_comp_in,
    .strobe_true_out, .strobe_comp_out, .strobe_oe
  );

  mem_rank_model u_mem
  (
    .link_clk, .rank_select_n, .act_n, .row_col_address, .bank_address,
    .data_bus_out, .data_bus_oe, .check_byte_bus_out, .rd_word, .rd_check,
    .data_bus_in, .check_byte_bus_in, .strobe_true_in, .strobe_comp_in
  );

  // Core clock, 10 ns
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Link clock, 32 ns, offset in phase
  initial
  begin
    #3.7;
    forever #16 link_clk = ~link_clk;
  end

  // Lane enables seen while the data bus is driven
  always @(posedge link_clk)
  begin
    if (&data_bus_oe)
    begin
      wr_dqs = strobe_oe;
      wr_ckoe = check_byte_bus_oe;
    end
  end

  // Read-result watcher and hang limit
  always @(posedge ref_clk)
  begin
    if (rd_valid !== rd_prev) rd_seen = 1'b1;
    rd_prev = rd_valid;
    cyc++;
    if (cyc > 5000)
    begin
      fail_count++;
      finish_test();
    end
  end

  // Compare one value, report a mismatch
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Byte-wise XOR check byte
  function automatic logic [7:0] par8(input logic [63:0] d);
    par8 = 8'h00;
    for (int i = 0; i < 8; i++) par8 ^= d[8*i +: 8];
  endfunction

  // Command lines A16..A14 for each non-activate command
  function automatic logic [2:0] enc(input int op);
    case (op)
      2: enc = 3'h5;
      3: enc = 3'h4;
      4: enc = 3'h2;
      5: enc = 3'h0;
      default: enc = 3'h1;
    endcase
  endfunction

  // One command with random fields; bad spoils the returned check byte
  task automatic do_cmd(input int op, input logic [1:0] rk, input logic bad);
    logic [23:0] c;
    logic [71:0] b;
    logic        a0;
    int          k;
    u_mem.cmd_q.delete();
    u_mem.beat_q.delete();
    @(posedge ref_clk);
    #1 rd_word = {$urandom, $urandom};
    rd_check = par8(rd_word) ^ {7'h00, bad};
    rd_seen = 1'b0;
    req_op = 3'(op);
    req_rank = rk;
    req_bank = 2'($urandom);
    req_addr = 17'($urandom);
    req_autopre = 1'($urandom);
    req_chop = 1'($urandom);
    a0 = req_ack;
    req_valid = 1'b1;
    k = 0;
    // Hold the request until the done toggle
    while (req_ack === a0 && k < 300)
    begin
      @(posedge ref_clk);
      k++;
    end
    #1 req_valid = 1'b0;
    check("done toggle", k < 300, 1'b1);
    repeat (12) @(posedge ref_clk);
    check("command count", u_mem.cmd_q.size(), 1);
    c = u_mem.cmd_q.size() ? u_mem.cmd_q[0] : 24'hFFFFFF;
    b = u_mem.beat_q.size() ? u_mem.beat_q[$] : 72'h0;
    check("select", c[23:20], 4'(~(4'h1 << rk)));
    check("activate line", c[19], op != 1);
    check("clock pair", mem_clock_comp, 4'(~mem_clock_true));
    if (op != 6) check("bank", c[18:17], req_bank);
    if (op == 1) check("row", c[16:0], req_addr);
    else check("command lines", c[16:14], enc(op));
    if (op == 4) check("all banks", c[10], req_autopre);
    // Column commands: precharge and chop bits, column address
    if (op == 2 || op == 3)
    begin
      check("auto precharge", c[10], req_autopre);
      check("burst chop", c[12], !req_chop);
      check("column", c[9:0], req_addr[9:0]);
    end
    // Read result and check-byte verdict
    if (op == 2)
    begin
      check("read data", rd_data, rd_word);
      check("check error", rd_check_err, bad & check_en);
      check("read beat", rd_seen, 1'b1);
    end
    // Write beat on the pins with its check byte
    if (op == 3)
    begin
      check("write data", b[63:0], head);
      check("write check", b[71:64], par8(head));
      check("write strobes", wr_dqs, check_en ? 9'h1FF : 9'h0FF);
      check("check lane enable", wr_ckoe, {8{check_en}});
    end
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(32'h2B84879B));
    // Reset held across several link edges
    repeat (16) @(posedge ref_clk);
    check("select idle", rank_select_n, 4'hF);
    check("clock enable idle", rank_clock_enable, 4'h0);
    check("termination idle", rank_termination, 4'h0);
    check("data enable idle", data_bus_oe, '0);
    #1 rst_n = 1'b1;
    // Per-rank levels follow the requests
    repeat (3)
    begin
      @(posedge ref_clk);
      #1 cke_req = 4'($urandom);
      odt_req = 4'($urandom);
      repeat (24) @(posedge ref_clk);
      check("clock enable", rank_clock_enable, cke_req);
      check("termination", rank_termination, odt_req);
    end
    #1 cke_req = 4'hF;
    // Fill the write buffer until it refuses
    n = 0;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge ref_clk);
      #1 wdata_valid = 1'b1;
      wdata = {$urandom, $urandom};
      if (wdata_ready === 1'b1)
      begin
        if (n == 0) head = wdata;
        n++;
      end
    end
    @(posedge ref_clk);
    #1 wdata_valid = 1'b0;
    check("buffer fill", n, FIFO_DEPTH);
    // Every command code except OP_NONE, on every rank in turn
    for (int op = 1; op < 7; op++) do_cmd(op, 2'(op), 1'b0);
    // Spoiled check byte, with and without check modules
    do_cmd(2, 2'h1, 1'b1);
    #1 check_en = 1'b0;
    do_cmd(2, 2'h2, 1'b1);
    finish_test();
  end
endmodule
